//--- csf_status_flags.sv
// Purpose: Thermistor, fault status and two event flag registers of a boost charger
// Assumes: Status inputs are asynchronous to ref_clk_in; read port is on ref_clk_in
// Notes:   Watchdog expiry only sets flag A bit 3 and resets no register here; read data is registered
`timescale 1ns/1ps

// Summary of operation
// R1: Zone code 3 bits in status bits 2:0
// R2: Reserved bits zero; zone code ignores register reset
// R3: Fault bit 7 tracks input overvoltage protection
// R4: Fault bit 6 tracks die thermal shutdown
// R5: Fault bit 4 tracks safety timer expiry
// R6: Flag A bit 6 on current-limit rise
// R7: Flag A bit 5 on voltage-limit rise
// R8: Flag A bit 4 on thermal-regulation rise
// R9: Flag A bit 3 on watchdog-expired rise
// R10: Flag A bit 0 on charge-state change
// R11: Flag B bit 7 on supply-good toggle
// R12: Flag B bit 4 on source-code change
// R13: Flag B bit 2 on zone-code change
// R14: Flag B bit 1 on optimizer change
// R15: Flags reset to zero; watchdog leaves them
// R16: Unmasked current-limit entry pulses host interrupt
// R17: Flags clear on read unless event recurs
module csf_status_flags
   import csf_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        arst_n_in,
   input  wire csf_status_s status_in,
   input  wire logic        reg_rst_cmd_in,
   input  wire logic        input_current_limit_mask_in,
   input  wire csf_rd_req_s rd_req_in,
   output logic [7:0]       rd_data_out,
   output logic             rd_valid_out,
   output logic             host_int_pulse_out
);

   // ==========================================================================
   // Input synchronisation
   csf_status_s stat_sync;

   csf_sync #(
      .W (CSF_STATUS_W)
   ) u_sync (
      .ref_clk_in (ref_clk_in),
      .arst_n_in  (arst_n_in),
      .d_in       (status_in),
      .q_out      (stat_sync)
   );

   // ==========================================================================
   // History for edge and change detection
   csf_status_s prev_ff;
   logic [2:0]  prime_sr_ff;
   // Three edges: two for the synchroniser to refill, one for history to catch up
   wire         primed = prime_sr_ff[2];

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prev_ff     <= '0;
         prime_sr_ff <= '0;
      end else begin
         prev_ff     <= stat_sync;
         prime_sr_ff <= {prime_sr_ff[1:0], 1'b1};
      end
   end

   // Synchroniser and history both restart from zero, so a live level would look
   // like an edge after reset; events wait until history holds a real sample
   wire rise_icur = primed & stat_sync.input_current_regulation
                    & ~prev_ff.input_current_regulation;
   wire rise_ivol = primed & stat_sync.input_voltage_regulation
                    & ~prev_ff.input_voltage_regulation;
   wire rise_dtmp = primed & stat_sync.die_temp_regulation
                    & ~prev_ff.die_temp_regulation;
   wire rise_wdog = primed & stat_sync.host_watchdog_expired
                    & ~prev_ff.host_watchdog_expired;
   wire chg_chrg  = primed & (stat_sync.charge_state_code != prev_ff.charge_state_code);
   wire chg_pgood = primed & (stat_sync.supply_good != prev_ff.supply_good);
   wire chg_src   = primed & (stat_sync.input_source_code != prev_ff.input_source_code);
   wire chg_ntc   = primed & (stat_sync.ntc_zone_code != prev_ff.ntc_zone_code);
   wire chg_ico   = primed
                    & (stat_sync.current_optimizer_state != prev_ff.current_optimizer_state);

   // ==========================================================================
   // Read decode
   wire rd_ntc   = rd_req_in.rd_stb & (rd_req_in.addr == CSF_ADDR_NTC_ZONE_STATUS);
   wire rd_fault = rd_req_in.rd_stb & (rd_req_in.addr == CSF_ADDR_FAULT_STATUS);
   wire rd_fa    = rd_req_in.rd_stb & (rd_req_in.addr == CSF_ADDR_EVENT_FLAGS_A);
   wire rd_fb    = rd_req_in.rd_stb & (rd_req_in.addr == CSF_ADDR_EVENT_FLAGS_B);

   // ==========================================================================
   // Event flags, one instance per bit position in each register, reserved ones masked
   logic [7:0] flags_a;
   logic [7:0] flags_b;
   logic [7:0] ev_a;
   logic [7:0] ev_b;
   logic [7:0] impl_a;
   logic [7:0] impl_b;

   always_comb begin
      ev_a = '0;
      ev_b = '0;
      ev_a[CSF_FA_INPUT_CURRENT] = rise_icur; // R6
      ev_a[CSF_FA_INPUT_VOLTAGE] = rise_ivol; // R7
      ev_a[CSF_FA_DIE_TEMP]      = rise_dtmp; // R8
      ev_a[CSF_FA_WATCHDOG]      = rise_wdog; // R9
      ev_a[CSF_FA_CHARGE_STATE]  = chg_chrg;  // R10
      ev_b[CSF_FB_SUPPLY_GOOD]   = chg_pgood; // R11
      ev_b[CSF_FB_INPUT_SOURCE]  = chg_src;   // R12
      ev_b[CSF_FB_NTC_ZONE]      = chg_ntc;   // R13
      ev_b[CSF_FB_OPTIMIZER]     = chg_ico;   // R14
      impl_a = '0;
      impl_b = '0;
      impl_a[CSF_FA_INPUT_CURRENT] = 1'b1;
      impl_a[CSF_FA_INPUT_VOLTAGE] = 1'b1;
      impl_a[CSF_FA_DIE_TEMP]      = 1'b1;
      impl_a[CSF_FA_WATCHDOG]      = 1'b1;
      impl_a[CSF_FA_CHARGE_STATE]  = 1'b1;
      impl_b[CSF_FB_SUPPLY_GOOD]   = 1'b1;
      impl_b[CSF_FB_INPUT_SOURCE]  = 1'b1;
      impl_b[CSF_FB_NTC_ZONE]      = 1'b1;
      impl_b[CSF_FB_OPTIMIZER]     = 1'b1;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         logic fa_q;
         logic fb_q;
         // Register reset clears, watchdog does not reach here
         csf_event_flag u_fa (
            .ref_clk_in (ref_clk_in),
            .arst_n_in  (arst_n_in),
            .event_in   (ev_a[gi]),
            .rd_clr_in  (rd_fa),            // R17
            .reg_rst_in (reg_rst_cmd_in),   // R15
            .flag_out   (fa_q)
         );
         csf_event_flag u_fb (
            .ref_clk_in (ref_clk_in),
            .arst_n_in  (arst_n_in),
            .event_in   (ev_b[gi]),
            .rd_clr_in  (rd_fb),            // R17
            .reg_rst_in (reg_rst_cmd_in),   // R15
            .flag_out   (fb_q)
         );
         // Reserved positions forced to zero
         assign flags_a[gi] = fa_q & impl_a[gi]; // R2
         assign flags_b[gi] = fb_q & impl_b[gi]; // R2
      end
   endgenerate

   // ==========================================================================
   // Live status images
   logic [7:0] ntc_img;
   logic [7:0] fault_img;

   always_comb begin
      ntc_img = '0; // R2
      ntc_img[CSF_NTC_ZONE_LSB +: 3] = stat_sync.ntc_zone_code; // R1
      fault_img = '0; // R2
      fault_img[CSF_FLT_OVERVOLTAGE] = stat_sync.input_overvoltage_active;     // R3
      fault_img[CSF_FLT_SHUTDOWN]    = stat_sync.die_overtemp_shutdown_active; // R4
      fault_img[CSF_FLT_TIMER]       = stat_sync.safety_timer_expired;         // R5
   end

   // ==========================================================================
   // Read mux; read returns the flag value before its clear
   wire [7:0] rd_mux = rd_ntc   ? ntc_img   :
                       rd_fault ? fault_img :
                       rd_fa    ? flags_a   :
                       rd_fb    ? flags_b   : CSF_RDATA_RESET;

   logic [7:0] rd_data_ff;
   logic       rd_valid_ff;
   logic       int_ff;

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rd_data_ff  <= CSF_RDATA_RESET;
         rd_valid_ff <= 1'b0;
         int_ff      <= 1'b0;
      end else begin
         rd_data_ff  <= rd_req_in.rd_stb ? rd_mux : rd_data_ff; // R17
         rd_valid_ff <= rd_req_in.rd_stb;
         int_ff      <= rise_icur & ~input_current_limit_mask_in; // R16
      end
   end

   assign rd_data_out        = rd_data_ff;
   assign rd_valid_out       = rd_valid_ff;
   assign host_int_pulse_out = int_ff;

endmodule : csf_status_flags

//--- csf_pkg.sv
// Purpose: Shared constants and types for the charger status and event flag bank
// Assumes: Registers are reached through the device's own register port (address, read strobe)
// Notes:   All register offsets, bit positions and reset values live here
package csf_pkg;

   // ==========================================================================
   // Register map
   localparam logic [7:0] CSF_ADDR_NTC_ZONE_STATUS = 8'h0D;
   localparam logic [7:0] CSF_ADDR_FAULT_STATUS    = 8'h0E;
   localparam logic [7:0] CSF_ADDR_EVENT_FLAGS_A   = 8'h0F;
   localparam logic [7:0] CSF_ADDR_EVENT_FLAGS_B   = 8'h10;
   localparam logic [7:0] CSF_FLAGS_RESET          = 8'h00;
   localparam logic [7:0] CSF_RDATA_RESET          = 8'h00;

   // ==========================================================================
   // Field positions
   localparam int CSF_NTC_ZONE_LSB       = 0;
   localparam int CSF_FLT_OVERVOLTAGE    = 7;
   localparam int CSF_FLT_SHUTDOWN       = 6;
   localparam int CSF_FLT_TIMER          = 4;
   localparam int CSF_FA_INPUT_CURRENT   = 6;
   localparam int CSF_FA_INPUT_VOLTAGE   = 5;
   localparam int CSF_FA_DIE_TEMP        = 4;
   localparam int CSF_FA_WATCHDOG        = 3;
   localparam int CSF_FA_CHARGE_STATE    = 0;
   localparam int CSF_FB_SUPPLY_GOOD     = 7;
   localparam int CSF_FB_INPUT_SOURCE    = 4;
   localparam int CSF_FB_NTC_ZONE        = 2;
   localparam int CSF_FB_OPTIMIZER       = 1;

   // ==========================================================================
   // Thermistor zone codes
   localparam logic [2:0] CSF_NTC_NORMAL = 3'h0;
   localparam logic [2:0] CSF_NTC_WARM   = 3'h2;
   localparam logic [2:0] CSF_NTC_COOL   = 3'h3;
   localparam logic [2:0] CSF_NTC_COLD   = 3'h5;
   localparam logic [2:0] CSF_NTC_HOT    = 3'h6;

   // ==========================================================================
   // Monitored status bundle, as produced by the charger core
   typedef struct packed {
      logic       input_current_regulation;
      logic       input_voltage_regulation;
      logic       die_temp_regulation;
      logic       host_watchdog_expired;
      logic [2:0] charge_state_code;
      logic       supply_good;
      logic [2:0] input_source_code;
      logic [2:0] ntc_zone_code;
      logic [1:0] current_optimizer_state;
      logic       input_overvoltage_active;
      logic       die_overtemp_shutdown_active;
      logic       safety_timer_expired;
   } csf_status_s;

   localparam int CSF_STATUS_W = $bits(csf_status_s);

   // Register read port request
   typedef struct packed {
      logic       rd_stb;
      logic [7:0] addr;
   } csf_rd_req_s;

endpackage : csf_pkg

//--- csf_sync.sv
// Purpose: Two-stage synchroniser for a bus of asynchronous levels
// Assumes: Each bit is an independent level from the analog core
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module csf_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk_in,
   input  wire logic         arst_n_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d_in;
         q_ff    <= meta_ff;
      end
   end

   assign q_out = q_ff;
endmodule : csf_sync

//--- csf_event_flag.sv
// Purpose: One sticky event flag with clear-on-read and register-reset clear
// Assumes: Event pulse and read strobe are on ref_clk_in
// Notes:   A new event in the read-clear cycle keeps the flag set; in a register-reset cycle the flag clears
`timescale 1ns/1ps
module csf_event_flag (
   input  wire logic ref_clk_in,
   input  wire logic arst_n_in,
   input  wire logic event_in,
   input  wire logic rd_clr_in,
   input  wire logic reg_rst_in,
   output logic      flag_out
);
   logic flag_ff;
   logic nxt_flag;

   // Register reset is a hard clear; otherwise set wins over read clear
   assign nxt_flag = reg_rst_in ? 1'b0 : (event_in | (flag_ff & ~rd_clr_in));

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag_out = flag_ff;
endmodule : csf_event_flag

//--- csf_status_flags_monitor.sv
// Purpose: Port checks for the charger status and event flag bank
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound onto every instance of the bank
`timescale 1ns/1ps
module csf_status_flags_monitor
   import csf_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        arst_n_in,
   input  wire csf_status_s status_in,
   input  wire logic        reg_rst_cmd_in,
   input  wire logic        input_current_limit_mask_in,
   input  wire csf_rd_req_s rd_req_in,
   input  wire logic [7:0]  rd_data_out,
   input  wire logic        rd_valid_out,
   input  wire logic        host_int_pulse_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);
   wire logic       rd  = rd_req_in.rd_stb;
   wire logic [7:0] ad  = rd_req_in.addr;
   wire logic [2:0] flt = {status_in.input_overvoltage_active,
                           status_in.die_overtemp_shutdown_active, status_in.safety_timer_expired};
   read_answer_a: assert property (rd |=> rd_valid_out)
      else $error("read not answered next cycle");
   unmapped_zero_a: assert property (rd && (ad < 8'h0D || ad > 8'h10) |=> rd_data_out == 8'h00)
      else $error("unmapped read not zero");
   zone_rsvd_a: assert property (rd && ad == 8'h0D |=> (rd_data_out & 8'hF8) == 8'h00)
      else $error("zone reserved bits set");
   fault_rsvd_a: assert property (rd && ad == 8'h0E |=> (rd_data_out & 8'h2F) == 8'h00)
      else $error("fault reserved bits set");
   flags_a_rsvd_a: assert property (rd && ad == 8'h0F |=> (rd_data_out & 8'h86) == 8'h00)
      else $error("flag A reserved bits set");
   flags_b_rsvd_a: assert property (rd && ad == 8'h10 |=> (rd_data_out & 8'h69) == 8'h00)
      else $error("flag B reserved bits set");
   zone_track_a: assert property ((($stable(status_in.ntc_zone_code))[*3]) ##0
      (rd && ad == 8'h0D && $past(arst_n_in, 3)) |=> rd_data_out[2:0] == $past(status_in.ntc_zone_code))
      else $error("zone code read wrong");
   fault_track_a: assert property ((($stable(flt))[*3]) ##0
      (rd && ad == 8'h0E && $past(arst_n_in, 3)) |=> {rd_data_out[7:6], rd_data_out[4]} == $past(flt))
      else $error("fault bits read wrong");
   int_masked_a: assert property (input_current_limit_mask_in[*4] |-> !host_int_pulse_out)
      else $error("masked interrupt pulse");
endmodule : csf_status_flags_monitor

bind csf_status_flags csf_status_flags_monitor csf_status_flags_monitor_i (
   .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .status_in(status_in),
   .reg_rst_cmd_in(reg_rst_cmd_in), .input_current_limit_mask_in(input_current_limit_mask_in),
   .rd_req_in(rd_req_in), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
   .host_int_pulse_out(host_int_pulse_out));

//--- csf_host_model.sv
// Purpose: Host side of the register read port
// Assumes: One read per call, answer one cycle after the strobe
// Notes:   Idle address shows the inverse of the last one, never a stale match
`timescale 1ns/1ps
module csf_host_model
   import csf_pkg::*;
(
   input  wire logic        ref_clk_in,
   output csf_rd_req_s      rd_req_out,
   input  wire logic [7:0]  rd_data_in,
   input  wire logic        rd_valid_in
);
   initial rd_req_out = '0;
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      rd_req_out <= '{rd_stb: 1'b1, addr: a};
      @(posedge ref_clk_in);
      rd_req_out <= '{rd_stb: 1'b0, addr: ~a};
      // Answer stands until this edge; taking it here returns the caller on an edge
      @(posedge ref_clk_in);
      d = (rd_valid_in === 1'b1) ? rd_data_in : 8'hXX;
   endtask : read
endmodule : csf_host_model

//--- testbench.sv
// Purpose: Self-checking bench for the status and event flag bank
// Assumes: Status levels change well apart, reads come from the host model
// Notes:   Each row waits long enough for sync and flag latency
`timescale 1ns/1ps
module testbench
   import csf_pkg::*;
   ;
   typedef struct packed {
      logic [CSF_STATUS_W-1:0] st;
      logic [7:0]              ad;
      logic [7:0]              ex;
   } csf_tb_row_s;
   logic        ref_clk_in     = 1'b0;
   logic        arst_n_in      = 1'b0;
   csf_status_s status_in      = '0;
   logic        reg_rst_cmd_in = 1'b0;
   logic        mask_in        = 1'b0;
   csf_rd_req_s rd_req;
   logic [7:0]  rd_data;
   logic        rd_valid;
   logic        int_pulse;
   logic [7:0]  d;
   logic [7:0]  int_cnt        = 8'h00;
   int          err_total      = 0;
   int          check_count    = 0;
   csf_tb_row_s rows [15] = '{
      '{19'h00040, 8'h0D, 8'h02}, '{19'h00060, 8'h0D, 8'h03},
      '{19'h000A0, 8'h0D, 8'h05}, '{19'h000C0, 8'h0D, 8'h06},
      '{19'h000C7, 8'h0E, 8'hD0},
      '{19'h000C7, 8'h10, 8'h04},
      '{19'h780C7, 8'h0F, 8'h78},
      '{19'h780C7, 8'h0F, 8'h00},
      '{19'h799CF, 8'h0F, 8'h01},
      '{19'h799CF, 8'h10, 8'h92},
      '{19'h799CF, 8'h11, 8'h00},
      '{19'h791CF, 8'h10, 8'h80},
      '{19'h79108, 8'h0E, 8'h00}, '{19'h79108, 8'h0D, 8'h00},
      '{19'h79108, 8'h10, 8'h04}};
   csf_status_flags csf_status_flags_i (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
      .status_in(status_in), .reg_rst_cmd_in(reg_rst_cmd_in),
      .input_current_limit_mask_in(mask_in), .rd_req_in(rd_req), .rd_data_out(rd_data),
      .rd_valid_out(rd_valid), .host_int_pulse_out(int_pulse));
   csf_host_model csf_host_model_i (.ref_clk_in(ref_clk_in), .rd_req_out(rd_req),
      .rd_data_in(rd_data), .rd_valid_in(rd_valid));
   initial forever #12.5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) if (int_pulse === 1'b1) int_cnt <= int_cnt + 8'h01;
   task automatic wait_n(input int n);
      repeat (n) @(posedge ref_clk_in);
   endtask : wait_n
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report
   // ==========================================================================
   // Tests
   initial begin
      wait_n(12);
      arst_n_in <= 1'b1;
      wait_n(4);
      for (int i = 0; i < 15; i++) begin
         status_in <= csf_status_s'(rows[i].st);
         wait_n(5);
         csf_host_model_i.read(rows[i].ad, d);
         chk(d, rows[i].ex);
         $display("row %0d done", i);
      end
      // Mid-run reset with live status: nothing may look like an event
      arst_n_in <= 1'b0;
      wait_n(3);
      arst_n_in <= 1'b1;
      wait_n(6);
      csf_host_model_i.read(8'h0F, d);
      chk(d, CSF_FLAGS_RESET);
      csf_host_model_i.read(8'h10, d);
      chk(d, CSF_FLAGS_RESET);
      $display("reset test done");
      for (int m = 0; m < 2; m++) begin
         mask_in <= m[0];
         status_in <= csf_status_s'(19'h39168);
         wait_n(5);
         status_in <= csf_status_s'(19'h79168);
         wait_n(5);
         reg_rst_cmd_in <= ~m[0];
         wait_n(1);
         reg_rst_cmd_in <= 1'b0;
         wait_n(2);
         csf_host_model_i.read(8'h0F, d);
         chk(d, m[0] ? 8'h40 : 8'h00);
         csf_host_model_i.read(8'h0D, d);
         chk(d, {5'h00, CSF_NTC_COOL});
         $display("command and mask test %0d done", m);
      end
      chk(int_cnt, 8'h02);
      final_report();
   end
   initial begin
      #20000;
      err_total++;
      $display("Error at %0t: watchdog expired", $time);
      final_report();
   end
endmodule : testbench
